//--- rtl/mpf_flow_control.v
// Ethernet MAC pause flow control with Avalon-MM registers and receive FIFO.
`timescale 1ns/10ps
`include "mpf_defines.vh"
module mpf_flow_control (
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire [7:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   input  wire [3:0]  AVS_BYTEENABLE,
   output reg  [31:0] AVS_READDATA,
   output wire        AVS_WAITREQUEST,
   input  wire        RX_VALID,
   output wire        RX_READY,
   input  wire [7:0]  RX_DATA,
   input  wire        RX_SOP,
   input  wire        RX_EOP,
   input  wire        RX_ERROR,
   output wire        APP_VALID,
   input  wire        APP_READY,
   output wire [7:0]  APP_DATA,
   output wire        APP_SOP,
   output wire        APP_EOP,
   output wire        APP_ERROR,
   output wire        APP_PKT_FILTER,
   output wire        TX_DISABLE,
   output wire        PAUSE_SEND_REQ,
   output wire [15:0] PAUSE_SEND_TIME,
   input  wire        PAUSE_SEND_DONE,
   output wire        BACKPRESSURE
);
   // States of the pause frame sender; HOLD waits for the trigger to drop
   // so that one request never yields a train of frames.
   localparam ST_IDLE = 2'b00;
   localparam ST_SEND = 2'b01;
   localparam ST_HOLD = 2'b10;

   // The macros are plain integers; keep them whole here and cut them
   // to the counter width on purpose below.
   localparam [31:0] FLOW_RESET_WORD = `MPF_FLOW_RESET;
   localparam [31:0] QUANTA_100_WORD = `MPF_QUANTA_CYC_100;
   localparam [31:0] QUANTA_10_WORD  = `MPF_QUANTA_CYC_10;
   localparam [11:0] QUANTA_100      = QUANTA_100_WORD[11:0];
   localparam [11:0] QUANTA_10       = QUANTA_10_WORD[11:0];

   // Flow register fields and the mode register.
   reg  [15:0] pause_time_value;
   reg         pass_control_frames;
   reg         pause_function_enable;
   reg  [4:0]  mode;
   wire        pause_tx_busy;
   wire        full_duplex;
   wire        speed_100;
   wire        tx_enable;
   wire        promiscuous;
   wire        flow_request;

   // Bus handshake.
   // The ack flop marks the cycle after the single wait cycle of each access.
   reg         bus_ack;
   wire        bus_req;
   wire [5:0]  word_index;
   wire        wr_take;
   wire        rd_take;
   reg  [31:0] next_readdata;

   // Receive decoder.
   // Bytes of a frame are counted from its start; index 31 saturates.
   reg  [4:0]  rx_idx;
   reg         rx_match;
   reg  [7:0]  time_hi;
   wire        rx_beat;
   wire [4:0]  cur_idx;
   reg  [7:0]  expect_byte;
   wire        next_match;
   wire        frame_is_pause;
   wire        pause_valid;
   wire [15:0] rx_pause_time;
   reg  [15:0] pause_count_src;
   reg  [7:0]  time_lo;
   wire        pkt_filter;
   wire [11:0] fifo_in;
   wire [11:0] fifo_out;
   wire [4:0]  fifo_level;

   // Pause timer.
   reg  [15:0] pause_count;
   reg  [11:0] quanta_div;
   wire [11:0] quanta_last;
   wire        quanta_tick;

   // Pause frame sender.
   reg  [1:0]  send_state;
   reg  [1:0]  next_send_state;
   wire        flow_trigger;
   wire        send_allowed;

   assign full_duplex  = mode[`MPF_MODE_FDX_BIT];
   assign speed_100    = mode[`MPF_MODE_SPD_BIT];
   assign tx_enable    = mode[`MPF_MODE_TXEN_BIT];
   assign promiscuous  = mode[`MPF_MODE_PROM_BIT];
   assign flow_request = mode[`MPF_MODE_REQ_BIT];

   // One wait cycle per access keeps read data a plain register.
   // Writes land at the edge that opens the access and reads latch there
   // too, so the data stands when the wait state ends; a master that holds
   // its request for the full handshake sees exactly one wait cycle.
   assign bus_req         = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = bus_req & ~bus_ack;
   assign word_index      = AVS_ADDRESS[7:2];
   assign wr_take         = AVS_WRITE & ~bus_ack;
   assign rd_take         = AVS_READ & ~bus_ack;

   always @* begin
      next_readdata = 32'h00000000;
      case (word_index)
         `MPF_FLOW_INDEX: begin
            next_readdata[31:16] = pause_time_value;
            next_readdata[`MPF_FLOW_PASS_BIT] = pass_control_frames;
            next_readdata[`MPF_FLOW_EN_BIT] = pause_function_enable;
            next_readdata[`MPF_FLOW_BUSY_BIT] = pause_tx_busy;
         end
         `MPF_MODE_INDEX: begin
            next_readdata[4:0] = mode;
         end
         // Read-only view of the live pause state; handy when software
         // has to tell a stalled transmitter from a slow link.
         `MPF_STAT_INDEX: begin
            next_readdata[31:16] = pause_count;
            next_readdata[8:4]   = fifo_level;
            next_readdata[2]     = BACKPRESSURE;
            next_readdata[1]     = PAUSE_SEND_REQ;
            next_readdata[0]     = TX_DISABLE;
         end
         default: begin
            next_readdata = 32'h00000000;
         end
      endcase
   end

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bus_ack               <= 1'b0;
         AVS_READDATA          <= 32'h00000000;
         pause_time_value      <= FLOW_RESET_WORD[31:16];
         pass_control_frames   <= 1'b0;
         pause_function_enable <= 1'b0;
         mode                  <= `MPF_MODE_RESET;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (rd_take) begin
            AVS_READDATA <= next_readdata;
         end
         // The busy bit position is read-only; whatever is written there
         // is dropped, so a careless write cannot fake an idle sender.
         if (wr_take && word_index == `MPF_FLOW_INDEX) begin
            // Byte lanes let software change the time without touching
            // the control bits, and the other way round.
            if (AVS_BYTEENABLE[3]) begin
               pause_time_value[15:8] <= AVS_WRITEDATA[31:24];
            end
            if (AVS_BYTEENABLE[2]) begin
               pause_time_value[7:0] <= AVS_WRITEDATA[23:16];
            end
            if (AVS_BYTEENABLE[0]) begin
               pass_control_frames <= AVS_WRITEDATA[`MPF_FLOW_PASS_BIT];
               pause_function_enable <= AVS_WRITEDATA[`MPF_FLOW_EN_BIT];
            end
         end
         // The mode word stands in for the rest of the MAC configuration.
         if (wr_take && word_index == `MPF_MODE_INDEX && AVS_BYTEENABLE[0]) begin
            mode <= AVS_WRITEDATA[4:0];
         end
      end
   end

   // Receive path: every beat goes to the FIFO untouched, whatever the
   // frame is; only the filter flag on the last beat is added here.
   assign rx_beat = RX_VALID & RX_READY;
   assign cur_idx = RX_SOP ? 5'd0 : rx_idx;
   // Fixed header bytes are compared one by one; source address and time
   // bytes match anything. A frame that breaks the pattern once stays
   // unmatched until its next start, since the match flag only chains.

   always @* begin
      case (cur_idx)
         5'd0:    expect_byte = `MPF_PAUSE_DA0;
         5'd1:    expect_byte = `MPF_PAUSE_DA1;
         5'd2:    expect_byte = `MPF_PAUSE_DA2;
         5'd3:    expect_byte = `MPF_PAUSE_DA3;
         5'd4:    expect_byte = `MPF_PAUSE_DA4;
         5'd5:    expect_byte = `MPF_PAUSE_DA5;
         5'd12:   expect_byte = `MPF_TYPE_HI;
         5'd13:   expect_byte = `MPF_TYPE_LO;
         5'd14:   expect_byte = `MPF_OPCODE_HI;
         5'd15:   expect_byte = `MPF_OPCODE_LO;
         default: expect_byte = RX_DATA;
      endcase
   end

   assign next_match = (RX_SOP | rx_match) & (RX_DATA == expect_byte);

   // Without the enable bit the decoder never reports a control frame.
   assign frame_is_pause = pause_function_enable & next_match &
                           (cur_idx >= `MPF_IDX_TIME_LO) & ~RX_ERROR;
   assign rx_pause_time  = (cur_idx == `MPF_IDX_TIME_LO) ?
                           {time_hi, RX_DATA} : pause_count_src;
   assign pause_valid    = rx_beat & RX_EOP & frame_is_pause & full_duplex;

   // The stored time bytes serve frames whose EOP comes after byte 17.
   always @* begin
      pause_count_src = {time_hi, time_lo};
   end

   // Promiscuous reception passes every frame, so it decides the flag
   // before the pass-control bit is looked at.
   assign pkt_filter = promiscuous ? 1'b1 :
                       (pass_control_frames ? frame_is_pause :
                        1'b0);

   assign fifo_in = {RX_EOP & pkt_filter, RX_ERROR, RX_EOP, RX_SOP, RX_DATA};

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_idx   <= 5'd0;
         rx_match <= 1'b0;
         time_hi  <= 8'h00;
         time_lo  <= 8'h00;
      end else if (rx_beat) begin
         rx_match <= next_match;
         if (cur_idx != 5'd31) begin
            rx_idx <= cur_idx + 5'd1;
         end
         if (cur_idx == `MPF_IDX_TIME_HI) begin
            time_hi <= RX_DATA;
         end
         if (cur_idx == `MPF_IDX_TIME_LO) begin
            time_lo <= RX_DATA;
         end
      end
   end

   // The application drains this FIFO and decides from the status bits
   // what to keep; a slow reader stalls the receiver through RX_READY.
   // Sixteen entries are only a skid buffer; frame storage lives beyond.
   mpf_fifo #(
      .WIDTH (`MPF_FIFO_WIDTH),
      .DEPTH (`MPF_FIFO_DEPTH),
      .AW    (`MPF_FIFO_AW)
   ) u_rx_fifo (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .in_valid  (RX_VALID),
      .in_ready  (RX_READY),
      .in_data   (fifo_in),
      .out_valid (APP_VALID),
      .out_ready (APP_READY),
      .out_data  (fifo_out),
      .level     (fifo_level)
   );

   assign APP_DATA       = fifo_out[7:0];
   assign APP_SOP        = fifo_out[8];
   assign APP_EOP        = fifo_out[9];
   assign APP_ERROR      = fifo_out[10];
   assign APP_PKT_FILTER = fifo_out[11];

   // Pause timer: one tick per slot time at the current link speed.
   // The divider restarts on every reload, so a new pause frame grants its
   // full time from its arrival rather than from the next slot boundary.
   assign quanta_last = speed_100 ? (QUANTA_100 - 12'd1) :
                                    (QUANTA_10 - 12'd1);
   assign quanta_tick = (quanta_div == quanta_last);

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pause_count <= 16'h0000;
         quanta_div  <= 12'h000;
      end else if (pause_valid) begin
         pause_count <= rx_pause_time;
         quanta_div  <= 12'h000;
      end else if (!pause_function_enable || !full_duplex) begin
         pause_count <= 16'h0000;
         quanta_div  <= 12'h000;
      end else if (pause_count != 16'h0000) begin
         if (quanta_tick) begin
            quanta_div  <= 12'h000;
            pause_count <= pause_count - 16'h0001;
         end else begin
            quanta_div <= quanta_div + 12'h001;
         end
      end
   end

   // Gated by the mode bits as well, so that dropping the enable or leaving
   // full duplex frees the transmitter in the same cycle, not one later.
   assign TX_DISABLE = (pause_count != 16'h0000) &
                       pause_function_enable & full_duplex;

   // Outgoing flow control: a software request or a filling FIFO.
   // The threshold leaves four free entries to absorb bytes already on
   // the way while the pause frame goes out.
   assign flow_trigger = flow_request | (fifo_level >= `MPF_FIFO_HIGH);
   assign send_allowed = tx_enable & pause_function_enable;

   always @* begin
      next_send_state = send_state;
      case (send_state)
         ST_IDLE: begin
            if (full_duplex & send_allowed & flow_trigger) begin
               next_send_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (PAUSE_SEND_DONE) begin
               next_send_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // One frame per request; the trigger must drop to re-arm.
            if (!flow_trigger) begin
               next_send_state = ST_IDLE;
            end
         end
         default: begin
            next_send_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         send_state <= ST_IDLE;
      end else begin
         send_state <= next_send_state;
      end
   end

   // Backpressure has no frame to finish, so it follows the trigger level
   // directly and busy drops with it.
   assign PAUSE_SEND_REQ  = (send_state == ST_SEND);
   assign PAUSE_SEND_TIME = pause_time_value;
   assign BACKPRESSURE    = ~full_duplex & send_allowed & flow_trigger;
   assign pause_tx_busy   = PAUSE_SEND_REQ | BACKPRESSURE;
endmodule

//--- rtl/mpf_defines.vh
// Register map, field positions, frame constants and timing of the pause block.
// Contract
// - With pass-control set, a valid pause frame gets the packet-filter flag set.
// - With pass-control clear, the packet-filter flag is cleared in receive status.
// - Every received frame, pause, missed or errored, is forwarded with status.
// - Promiscuous filtering overrides the pass-control setting for the filter flag.
// - Pause frames act only in full duplex with the enable bit set.
// - A valid pause stalls the transmitter for pause time times slot time.
// - With enable clear, frames are not examined and pause is inactive.
// - In half duplex the enable bit turns on receive backpressure.
// - Busy reads 1 while a pause frame or backpressure is being sent.
// - Busy returns to 0 when the pause frame transmission has finished.
// - The upper sixteen flow register bits give the transmitted pause time.
// - With the transmitter disabled, no pause frame and no backpressure.
`ifndef MPF_DEFINES_VH
`define MPF_DEFINES_VH

`define MPF_FLOW_INDEX       6'h08
`define MPF_MODE_INDEX       6'h10
`define MPF_STAT_INDEX       6'h11

`define MPF_FLOW_RESET       32'h00000000
`define MPF_FLOW_BUSY_BIT    0
`define MPF_FLOW_EN_BIT      1
`define MPF_FLOW_PASS_BIT    2
`define MPF_FLOW_TIME_LSB    16

`define MPF_MODE_FDX_BIT     0
`define MPF_MODE_SPD_BIT     1
`define MPF_MODE_TXEN_BIT    2
`define MPF_MODE_PROM_BIT    3
`define MPF_MODE_REQ_BIT     4
`define MPF_MODE_RESET       5'h00

`define MPF_PAUSE_DA0        8'h01
`define MPF_PAUSE_DA1        8'h80
`define MPF_PAUSE_DA2        8'hC2
`define MPF_PAUSE_DA3        8'h00
`define MPF_PAUSE_DA4        8'h00
`define MPF_PAUSE_DA5        8'h01
`define MPF_TYPE_HI          8'h88
`define MPF_TYPE_LO          8'h08
`define MPF_OPCODE_HI        8'h00
`define MPF_OPCODE_LO        8'h01
`define MPF_IDX_TIME_HI      5'd16
`define MPF_IDX_TIME_LO      5'd17

`define MPF_CLK_PERIOD_NS    20
`define MPF_SLOT_BITS        512
`define MPF_BIT_NS_100       10
`define MPF_BIT_NS_10        100
`define MPF_QUANTA_CYC_100   ((`MPF_SLOT_BITS*`MPF_BIT_NS_100)/`MPF_CLK_PERIOD_NS)
`define MPF_QUANTA_CYC_10    ((`MPF_SLOT_BITS*`MPF_BIT_NS_10)/`MPF_CLK_PERIOD_NS)

`define MPF_FIFO_WIDTH       12
`define MPF_FIFO_DEPTH       16
`define MPF_FIFO_AW          4
`define MPF_FIFO_HIGH        5'd12

`endif

//--- rtl/mpf_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module mpf_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             reset_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output reg  [AW:0]      level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   wire            push;
   wire            pop;

   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         level  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            level <= level + 1'b1;
         end else if (pop & ~push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule

//--- test/mpf_flow_control_sva.sv
// Port-level checks of the pause flow control block.
`timescale 1ns/10ps
`include "mpf_defines.vh"
module mpf_flow_control_sva (
   input wire        CLK,
   input wire        RESET_N,
   input wire [7:0]  AVS_ADDRESS,
   input wire        AVS_READ,
   input wire        AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0]  AVS_BYTEENABLE,
   input wire [31:0] AVS_READDATA,
   input wire        AVS_WAITREQUEST,
   input wire        APP_VALID,
   input wire        APP_EOP,
   input wire        APP_PKT_FILTER,
   input wire        TX_DISABLE,
   input wire        PAUSE_SEND_REQ,
   input wire [15:0] PAUSE_SEND_TIME,
   input wire        PAUSE_SEND_DONE,
   input wire        BACKPRESSURE
);
   localparam [7:0] A_FLOW = {`MPF_FLOW_INDEX, 2'h0};
   localparam [7:0] A_MODE = {`MPF_MODE_INDEX, 2'h0};
   // Shadows follow the take edge so they change with the real registers.
   wire       wr = AVS_WRITE && AVS_WAITREQUEST;
   reg  [4:0] mode;
   reg  [2:1] flow;
   always @(posedge CLK or negedge RESET_N)
      if (!RESET_N) begin
         mode <= 5'h00;
         flow <= 2'h0;
      end else if (wr && AVS_ADDRESS == A_MODE && AVS_BYTEENABLE[0])
         mode <= AVS_WRITEDATA[4:0];
      else if (wr && AVS_ADDRESS == A_FLOW && AVS_BYTEENABLE[0])
         flow <= AVS_WRITEDATA[2:1];
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   a_time_field: assert property (
      wr && AVS_ADDRESS == A_FLOW && AVS_BYTEENABLE[3:2] == 2'h3
      |=> PAUSE_SEND_TIME == AVS_WRITEDATA[31:16]) else $error("bad time");
   a_busy_read: assert property (
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == A_FLOW &&
      $stable(PAUSE_SEND_REQ) && $stable(BACKPRESSURE)
      |-> AVS_READDATA[0] == (PAUSE_SEND_REQ || BACKPRESSURE))
      else $error("bad busy");
   a_done_clears: assert property (
      PAUSE_SEND_REQ && PAUSE_SEND_DONE |=> !PAUSE_SEND_REQ [*2])
      else $error("request outlives done");
   a_bp_half: assert property (
      !mode[0] && mode[2] && mode[4] && flow[1] |-> BACKPRESSURE)
      else $error("no backpressure");
   a_bp_gate: assert property (
      mode[0] || !mode[2] || !flow[1] |-> !BACKPRESSURE)
      else $error("stray backpressure");
   a_stall_gate: assert property (
      !flow[1] || !mode[0] |-> !TX_DISABLE) else $error("stray stall");
   a_filter_cause: assert property (
      APP_VALID && APP_PKT_FILTER |-> APP_EOP && (mode[3] || flow[2]))
      else $error("stray filter flag");
   a_prom_wins: assert property (
      APP_VALID && APP_EOP && mode[3] |-> APP_PKT_FILTER)
      else $error("filter flag lost");
   c_stall: cover property ($rose(TX_DISABLE));
   c_bp: cover property (BACKPRESSURE);
   c_done: cover property (PAUSE_SEND_REQ && PAUSE_SEND_DONE);
endmodule

//--- test/mpf_link_partner.sv
// Link partner model: received byte stream and pause send acknowledge.
`timescale 1ns/10ps
module mpf_link_partner (
   input  wire       clk,
   input  wire       rx_ready,
   output reg        rx_valid,
   output reg  [7:0] rx_data,
   output reg        rx_sop,
   output reg        rx_eop,
   output reg        rx_error,
   input  wire       send_req,
   output reg        send_done
);
   localparam [127:0] HDR = 128'h0180C2000001_021122334455_8808_0001;
   integer delay;
   integer cnt;
   initial begin
      rx_valid  = 1'h0;
      rx_data   = 8'h00;
      rx_sop    = 1'h0;
      rx_eop    = 1'h0;
      rx_error  = 1'h0;
      send_done = 1'h0;
      delay     = 2;
      cnt       = 0;
   end
   // A settable delay lets the bench play a slow transmitter.
   always @(posedge clk) begin
      send_done <= send_req && !send_done && cnt >= delay;
      cnt <= (send_req && !send_done && cnt < delay) ? cnt + 1 : 0;
   end
   task send_frame(input p, input [15:0] t, input e, input integer len);
      integer i;
      integer n;
      begin
         for (i = 0; i < len; i = i + 1) begin
            rx_valid <= 1'h1;
            rx_data  <= i > 17 ? i[7:0] : i > 15 ? t[8*(17-i) +: 8] :
                        (!p && (i == 0 || i == 12)) ? 8'h02 :
                        HDR[127-8*i -: 8];
            rx_sop   <= i == 0;
            rx_eop   <= i == len - 1;
            rx_error <= e && i == len - 1;
            n = 0;
            @(posedge clk);
            while (!rx_ready && n < 500) begin
               n = n + 1;
               @(posedge clk);
            end
         end
         // Released data lines toggle so nobody can lean on a stale byte.
         rx_valid <= 1'h0;
         rx_data  <= ~rx_data;
         @(posedge clk);
      end
   endtask
endmodule

//--- test/tb_mpf_flow_control.sv
// Self-checking bench of the pause flow control block.
`timescale 1ns/10ps
`include "mpf_defines.vh"
module tb_mpf_flow_control;
   localparam [7:0] A_FLOW = {`MPF_FLOW_INDEX, 2'h0};
   localparam [7:0] A_MODE = {`MPF_MODE_INDEX, 2'h0};
   localparam [7:0] A_STAT = {`MPF_STAT_INDEX, 2'h0};
   localparam       QC     = `MPF_QUANTA_CYC_100;
   reg         CLK, RESET_N, AVS_READ, AVS_WRITE, APP_READY, last_flt;
   reg  [7:0]  AVS_ADDRESS;
   reg  [7:0]  first_dat, last_dat;
   reg         last_err;
   reg  [31:0] AVS_WRITEDATA, q;
   wire [3:0]  AVS_BYTEENABLE = 4'hF;
   wire [31:0] AVS_READDATA;
   wire [7:0]  RX_DATA, APP_DATA;
   wire [15:0] PAUSE_SEND_TIME;
   wire        AVS_WAITREQUEST, RX_VALID, RX_READY, RX_SOP, RX_EOP;
   wire        RX_ERROR, APP_VALID, APP_SOP, APP_EOP, APP_ERROR;
   wire        APP_PKT_FILTER, TX_DISABLE, PAUSE_SEND_REQ;
   wire        PAUSE_SEND_DONE, BACKPRESSURE;
   integer     fail_count, n_compared, frames, n, k;
   mpf_flow_control mpf_flow_control_inst (.CLK, .RESET_N, .AVS_ADDRESS,
      .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
      .AVS_WAITREQUEST, .RX_VALID, .RX_READY, .RX_DATA, .RX_SOP, .RX_EOP,
      .RX_ERROR, .APP_VALID, .APP_READY, .APP_DATA, .APP_SOP, .APP_EOP,
      .APP_ERROR, .APP_PKT_FILTER, .TX_DISABLE, .PAUSE_SEND_REQ,
      .PAUSE_SEND_TIME, .PAUSE_SEND_DONE, .BACKPRESSURE);
   mpf_link_partner lp_inst (.clk(CLK), .rx_ready(RX_READY),
      .rx_valid(RX_VALID), .rx_data(RX_DATA), .rx_sop(RX_SOP),
      .rx_eop(RX_EOP), .rx_error(RX_ERROR), .send_req(PAUSE_SEND_REQ),
      .send_done(PAUSE_SEND_DONE));
   always #10 CLK = ~CLK;
   always @(posedge CLK)
      if (APP_VALID && APP_READY) begin
         if (APP_SOP)
            first_dat <= APP_DATA;
         if (APP_EOP) begin
            frames   <= frames + 1;
            last_flt <= APP_PKT_FILTER;
            last_err <= APP_ERROR;
            last_dat <= APP_DATA;
         end
      end
   task end_sim;
      begin
         if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count = fail_count + 1;
         end
      end
   endtask
   function cond(input integer s);
      case (s)
         0: cond = AVS_WAITREQUEST === 1'h0;
         1: cond = TX_DISABLE === 1'h0;
         2: cond = RX_READY === 1'h0;
         3: cond = PAUSE_SEND_REQ === 1'h0;
         default: cond = frames == n;
      endcase
   endfunction
   task wait_on(input integer s);
      begin
         k = 0;
         while (!cond(s) && k < 1000) begin
            k = k + 1;
            @(posedge CLK);
         end
         chk(k < 1000, 1);
         if (k >= 1000)
            end_sim;
      end
   endtask
   task bus_op(input w, input [7:0] a, input [31:0] d);
      begin
         AVS_ADDRESS   <= a;
         AVS_WRITEDATA <= d;
         AVS_WRITE     <= w;
         AVS_READ      <= !w;
         @(posedge CLK);
         wait_on(0);
         q = AVS_READDATA;
         AVS_WRITE <= 1'h0;
         AVS_READ  <= 1'h0;
         @(posedge CLK);
      end
   endtask
   task t_regs;
      begin
         bus_op(0, A_FLOW, 0);
         chk(q, `MPF_FLOW_RESET);
         bus_op(0, A_MODE, 0);
         chk(q, 0);
         bus_op(1, 8'h00, 32'hFFFFFFFF);
         bus_op(0, 8'h00, 0);
         chk(q, 0);
         bus_op(1, A_FLOW, 32'h00020006);
         bus_op(0, A_FLOW, 0);
         chk(q, 32'h00020006);
         chk(PAUSE_SEND_TIME, 16'h0002);
      end
   endtask
   task t_rx(input [4:0] m, input [2:0] f, input e, input s, input p);
      begin
         bus_op(1, A_MODE, {27'h0, m});
         bus_op(1, A_FLOW, {29'h0, f});
         n = frames + 1;
         lp_inst.send_frame(1, 16'h0001, e, 20);
         wait_on(4);
         chk(TX_DISABLE, s);
         chk(last_flt, p);
         chk(first_dat, 8'h01);
         chk(last_dat, 8'h13);
         chk(last_err, e);
         wait_on(1);
      end
   endtask
   task t_decode;
      begin
         t_rx(5'h03, 3'h6, 0, 1, 1);
         t_rx(5'h02, 3'h6, 0, 0, 1);
         t_rx(5'h03, 3'h4, 0, 0, 0);
         t_rx(5'h03, 3'h2, 0, 1, 0);
         t_rx(5'h0B, 3'h2, 0, 1, 1);
         t_rx(5'h03, 3'h6, 1, 0, 0);
      end
   endtask
   task t_reload;
      begin
         bus_op(1, A_MODE, 32'h03);
         bus_op(1, A_FLOW, 32'h02);
         lp_inst.send_frame(1, 16'h0001, 0, 20);
         lp_inst.send_frame(1, 16'h0002, 0, 20);
         wait_on(1);
         chk(k > QC && k <= 2 * QC + 8, 1);
         lp_inst.send_frame(1, 16'h0000, 0, 20);
         chk(TX_DISABLE, 0);
      end
   endtask
   task t_fill;
      begin
         APP_READY <= 1'h0;
         lp_inst.delay = 40;
         bus_op(1, A_MODE, 32'h07);
         bus_op(1, A_FLOW, 32'h00030002);
         n = frames + 1;
         fork
            lp_inst.send_frame(0, 0, 0, 24);
         join_none
         wait_on(2);
         chk(PAUSE_SEND_REQ, 1);
         bus_op(0, A_FLOW, 0);
         chk(q, 32'h00030003);
         bus_op(0, A_STAT, 0);
         chk(q[8:0], 9'h102);
         wait_on(3);
         bus_op(0, A_FLOW, 0);
         chk(q, 32'h00030002);
         APP_READY <= 1'h1;
         wait_on(4);
         lp_inst.delay = 2;
      end
   endtask
   task t_bp;
      begin
         lp_inst.delay = 20;
         bus_op(1, A_MODE, 32'h16);
         bus_op(1, A_FLOW, 32'h02);
         chk(BACKPRESSURE, 1);
         bus_op(0, A_FLOW, 0);
         chk(q, 32'h03);
         bus_op(1, A_MODE, 32'h12);
         chk(BACKPRESSURE, 0);
         bus_op(1, A_MODE, 32'h11);
         chk(PAUSE_SEND_REQ, 0);
         bus_op(1, A_MODE, 32'h15);
         chk(PAUSE_SEND_REQ, 1);
         wait_on(3);
         bus_op(1, A_MODE, 0);
      end
   endtask
   initial begin
      CLK = 1'h0;
      RESET_N = 1'h0;
      AVS_ADDRESS = 8'h00;
      AVS_READ = 1'h0;
      AVS_WRITE = 1'h0;
      AVS_WRITEDATA = 32'h0;
      APP_READY = 1'h1;
      last_flt = 1'h0;
      fail_count = 0;
      n_compared = 0;
      frames = 0;
      n = 0;
      k = 0;
      repeat (20) @(posedge CLK);
      RESET_N <= 1'h1;
      @(posedge CLK);
      t_regs;
      t_decode;
      t_reload;
      t_fill;
      t_bp;
      end_sim;
   end
endmodule
bind mpf_flow_control mpf_flow_control_sva mpf_flow_control_sva_inst (
   .CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
   .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .APP_VALID, .APP_EOP,
   .APP_PKT_FILTER, .TX_DISABLE, .PAUSE_SEND_REQ, .PAUSE_SEND_TIME,
   .PAUSE_SEND_DONE, .BACKPRESSURE);
